// *** dv/dvid_core_model.sv ***
/*
  processor-core model issuing table reads and writes.
  assumes rsp stands one cycle, one cycle after the read edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dvid_core_model (
  input wire logic clk,
  output var dvid_pkg::dvid_req_t req,
  input wire dvid_pkg::dvid_rsp_t rsp
);
  initial req = '0;
  task automatic op(input logic rd, input logic wr, input logic [23:0] ad,
      input logic [23:0] wd, output dvid_pkg::dvid_rsp_t got);
    @(posedge clk);
    #1 req = '{rd: rd, wr: wr, addr: ad, wdata: wd};
    @(posedge clk);
    #1 got = rsp;
    // released lines show inverse, not the old value
    req = '{rd: 1'b0, wr: 1'b0, addr: ~ad, wdata: ~wd};
  endtask : op
endmodule : dvid_core_model
`default_nettype wire

// *** dv/testbench.sv ***
/*
  self-checking bench for the identity block against a queue model.
  assumes the core model is the only driver of req.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  dvid_pkg::dvid_req_t req;
  dvid_pkg::dvid_rsp_t rsp, got;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 48;
  int unit_q[$];
  logic [23:0] a;
  dvid_identity u_dut (.clk(clk), .reset(reset), .req(req), .rsp(rsp));
  dvid_core_model u_core (.clk(clk), .req(req), .rsp(rsp));
  initial forever #20 clk = ~clk;
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [25:0] model(input logic [23:0] ad);
    if (ad == dvid_pkg::PART_IDENTITY_ADDR) return {10'h300, dvid_pkg::PART_IDENTITY_VALUE};
    if (ad == dvid_pkg::SILICON_REVISION_ADDR) return {10'h300, dvid_pkg::SILICON_REVISION_VALUE};
    if (ad[23:3] == dvid_pkg::UNIT_ID_BASE_ADDR[23:3]) return {10'h300, 16'(unit_q[ad[2:1]])};
    return {2'b10, 24'h000000};
  endfunction : model
  task automatic rd(input logic [23:0] ad);
    u_core.op(1'b1, 1'b0, ad, 24'h000000, got);
    check(got, model(ad));
  endtask : rd
  task automatic wr(input logic [23:0] ad, input logic [23:0] wd, input logic also_rd);
    logic [25:0] e;
    e = also_rd ? model(ad) : 26'h0000000;
    u_core.op(also_rd, 1'b1, ad, wd, got);
    check(got, e);
    if (ad[23:3] == dvid_pkg::UNIT_ID_BASE_ADDR[23:3]) unit_q[ad[2:1]] = int'(wd[15:0]);
  endtask : wr
  task automatic hit_reset(input int n);
    @(posedge clk);
    #1 reset = 1'b1;
    unit_q = '{32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff};
    repeat (n) @(posedge clk);
    #1 reset = 1'b0;
  endtask : hit_reset
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #80000;
    n_fail++;
    stop_test();
  end
  initial begin
    hit_reset(6);
    for (int k = 0; k < 2; k++) begin
      wr(dvid_pkg::PART_IDENTITY_ADDR, 24'(k - 1), k[0]);
      wr(dvid_pkg::SILICON_REVISION_ADDR, 24'hffffff, ~k[0]);
      for (int i = 0; i < 16; i++) begin
        a = dvid_pkg::UNIT_ID_BASE_ADDR | 24'($random(seed) & 7);
        wr(a, 24'($random(seed)), i[0]);
        rd(a);
        rd(24'($random(seed)));
      end
      rd(dvid_pkg::PART_IDENTITY_ADDR);
      rd(dvid_pkg::SILICON_REVISION_ADDR);
      hit_reset(2);
      for (int i = 0; i < 8; i++) rd(dvid_pkg::UNIT_ID_BASE_ADDR + 24'(i));
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// *** src/dvid_identity.sv ***
/*
  Device identity registers on the table-read path: part identity,
  silicon revision and unit identification words.
  Assumes the core issues one-cycle table read and write strobes on clk.
*/
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - two identity registers, writes never change them
// - 24-bit words, only low sixteen bits stored
// - bits 23 to 16 read zero
// - values reached through table reads
// - fixed identity addresses near top of program space, unit words at 0x800f80
// - part identity holds family and part number
// - revision holds major and minor levels
// - user-programmable unit identification words
module dvid_identity (
  input wire logic clk,
  input wire logic reset,
  input wire dvid_pkg::dvid_req_t req,
  output dvid_pkg::dvid_rsp_t rsp
);
  typedef struct packed {
    dvid_pkg::dvid_rsp_t rsp;
  } dvid_state_t;

  dvid_state_t state;
  dvid_state_t next_state;
  logic unit_sel_rd;
  logic unit_sel_wr;
  logic [15:0] unit_rdata;

  // unit words sit on even addresses of a small window
  assign unit_sel_rd = req.addr[23:3] == dvid_pkg::UNIT_ID_BASE_ADDR[23:3];
  // only the unit window takes writes, identity words have no storage
  assign unit_sel_wr = req.wr && unit_sel_rd;

  dvid_unit_words u_unit (
    .clk(clk),
    .reset(reset),
    .wr_en(unit_sel_wr),
    .wr_index(req.addr[2:1]),
    .wr_data(req.wdata[15:0]),
    .rd_index(req.addr[2:1]),
    .rd_data(unit_rdata)
  );

  // writes to identity addresses fall through unused
  always_comb begin
    next_state = '0;
    if (req.rd) begin
      next_state.rsp.valid = 1'b1;
      if (req.addr == dvid_pkg::PART_IDENTITY_ADDR) begin
        next_state.rsp.hit = 1'b1;
        next_state.rsp.rdata = {dvid_pkg::UPPER_ZERO, dvid_pkg::PART_IDENTITY_VALUE};
      end else if (req.addr == dvid_pkg::SILICON_REVISION_ADDR) begin
        next_state.rsp.hit = 1'b1;
        next_state.rsp.rdata = {dvid_pkg::UPPER_ZERO, dvid_pkg::SILICON_REVISION_VALUE};
      end else if (unit_sel_rd) begin
        next_state.rsp.hit = 1'b1;
        next_state.rsp.rdata = {dvid_pkg::UPPER_ZERO, unit_rdata};
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // identity values are constants, untouched by reset
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rsp = state.rsp;

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset)
    rsp.valid |-> rsp.rdata[23:16] == 8'h00)
    else $error("upper byte not zero");
  AST_PART_READ: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.addr == dvid_pkg::PART_IDENTITY_ADDR
      |=> rsp.valid && rsp.hit && rsp.rdata == 24'h001234)
    else $error("part identity read wrong");
  AST_REV_READ: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.addr == dvid_pkg::SILICON_REVISION_ADDR
      |=> rsp.valid && rsp.hit && rsp.rdata == 24'h000001)
    else $error("revision read wrong");
  AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.rd && req.addr == dvid_pkg::PART_IDENTITY_ADDR
      |=> rsp.rdata[15:0] == 16'h1234)
    else $error("identity changed by write");
  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
    req.rd |=> rsp.valid)
    else $error("read not answered");
  AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (reset)
    !req.rd |=> !rsp.valid && rsp.rdata == 24'h000000)
    else $error("answer without read");
  AST_UNIT_WRITE: assert property (@(posedge clk) disable iff (reset)
    req.wr && unit_sel_rd && !req.rd ##1 !req.wr
      ##1 (req.rd && req.addr == $past(req.addr, 2))
      |=> rsp.rdata[15:0] == $past(req.wdata[15:0], 3))
    else $error("unit word not stored");
  AST_HIT_NEEDS_VALID: assert property (@(posedge clk) disable iff (reset)
    rsp.hit |-> rsp.valid)
    else $error("hit without valid");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.addr != dvid_pkg::PART_IDENTITY_ADDR
      && req.addr != dvid_pkg::SILICON_REVISION_ADDR && !unit_sel_rd
      |=> !rsp.hit && rsp.rdata == 24'h000000)
    else $error("unmapped read hit");
endmodule : dvid_identity
`default_nettype wire

// *** src/dvid_pkg.sv ***
/*
  Package for the device identity register block: table-read addresses,
  field layout and fixed values.
  Assumes a 24-bit program-word data path and a 24-bit table address.
*/
package dvid_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned VAL_W = 16;
  localparam int unsigned UNIT_WORDS = 4;
  // identity addresses near the top of program space, unit words at 0x800f80; placement is arbitrary
  localparam logic [23:0] PART_IDENTITY_ADDR = 24'hff0000;
  localparam logic [23:0] SILICON_REVISION_ADDR = 24'hff0002;
  localparam logic [23:0] UNIT_ID_BASE_ADDR = 24'h800f80;
  // identity values arbitrary, chosen for this design only
  localparam logic [15:0] PART_IDENTITY_VALUE = 16'h1234;
  localparam logic [15:0] SILICON_REVISION_VALUE = 16'h0001;
  localparam logic [15:0] UNIT_ID_RESET = 16'hffff;
  localparam logic [7:0] UPPER_ZERO = 8'h00;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [23:0] wdata;
  } dvid_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [23:0] rdata;
  } dvid_rsp_t;
endpackage : dvid_pkg

// *** src/dvid_unit_words.sv ***
/*
  User-programmable unit identification words, flip-flop storage.
  Assumes writes come only from the table-write path on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dvid_unit_words (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [1:0] wr_index,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_index,
  output logic [15:0] rd_data
);
  typedef struct packed {
    logic [dvid_pkg::UNIT_WORDS-1:0][15:0] word;
  } dvid_unit_state_t;

  dvid_unit_state_t state;
  dvid_unit_state_t next_state;

  // every word reads all ones after each reset until written
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.word[wr_index] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= {dvid_pkg::UNIT_WORDS{dvid_pkg::UNIT_ID_RESET}};
    end else begin
      state <= next_state;
    end
  end

  assign rd_data = state.word[rd_index];
endmodule : dvid_unit_words
`default_nettype wire
